// [rtl/gpw_pkg.sv]
package gpw_pkg;

    localparam int NPORT = 7;
    localparam int PW    = 8;
    localparam int AW    = 8;

    typedef logic [PW-1:0]            gpw_byte_t;
    typedef logic [NPORT-1:0][PW-1:0] gpw_bank_t;

    // ports in order g f e d c b a
    localparam gpw_bank_t IMPL_MASK = {8'h03, 8'hff, 8'hff, 8'hff,
                                       8'hff, 8'hff, 8'hff};
    localparam gpw_bank_t PU_MASK   = {8'h03, 8'hff, 8'hff, 8'hff,
                                       8'h7f, 8'hff, 8'hff};
    localparam gpw_bank_t DIR_RST   = IMPL_MASK;
    localparam gpw_bank_t DATA_RST  = IMPL_MASK;
    localparam gpw_bank_t PU_RST    = '0;
    localparam gpw_byte_t WAKE_RST  = 8'h00;
    localparam gpw_byte_t BYTE_ZERO = 8'h00;

    // address group codes (bits 7:5) and byte addresses
    localparam logic [2:0] GRP_DATA  = 3'h0;
    localparam logic [2:0] GRP_DIR   = 3'h1;
    localparam logic [2:0] GRP_PU    = 3'h2;
    localparam logic [AW-1:0] OFS_WAKE  = 8'h60;
    localparam logic [AW-1:0] OFS_FN    = 8'h64;
    localparam logic [AW-1:0] OFS_ADC   = 8'h68;
    localparam logic [AW-1:0] OFS_LCD   = 8'h6c;
    localparam logic [AW-1:0] OFS_ISTAT = 8'h70;
    localparam logic [AW-1:0] OFS_IMASK = 8'h74;

    // function control fields
    localparam int FN_PFD  = 0;
    localparam int FN_IRQ  = 1;
    localparam int FN_TMR  = 3;
    localparam int FN_PWM  = 8;
    localparam logic [15:0] FN_RST = 16'h0000;

    // pin placement of shared functions
    localparam int PORT_A   = 0;
    localparam int PORT_B   = 1;
    localparam int PORT_D   = 3;
    localparam int PFD_BIT  = 3;
    localparam int IRQ0_BIT = 4;
    localparam int IRQ1_BIT = 6;
    localparam int TMR0_BIT = 5;
    localparam int TMR1_BIT = 7;
    localparam int ADC_PORT = PORT_B;
    localparam int NPWM     = 4;
    localparam int NCOM     = 4;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

endpackage

// [rtl/gpw_top.sv]
module gpw_top (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [gpw_pkg::AW-1:0] awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [gpw_pkg::AW-1:0] araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    input  wire gpw_pkg::gpw_bank_t   pin_i,
    output gpw_pkg::gpw_bank_t        pin_o,
    output gpw_pkg::gpw_bank_t        pin_oe,
    output gpw_pkg::gpw_bank_t        pin_pullup,
    input  wire logic                 freq_divider_in,
    input  wire logic [3:0]           pwm_in,
    output logic [1:0]                ext_irq_pins,
    output logic [1:0]                timer_input_pin,
    output logic [3:0]                lcd_common_pins,
    input  wire logic                 sleep_i,
    output logic                      wake_o,
    output logic                      irq_o
);
    import gpw_pkg::*;

    typedef struct packed {
        gpw_bank_t   sync1;
        gpw_bank_t   sync2;
        gpw_byte_t   prev_a;
        gpw_bank_t   data;
        gpw_bank_t   dir;
        gpw_bank_t   pu;
        gpw_byte_t   wake_en;
        logic [15:0] fn;
        gpw_byte_t   adc_sel;
        gpw_byte_t   lcd;
        gpw_byte_t   istat;
        gpw_byte_t   imask;
        logic        wake;
        logic        aw_got;
        logic [AW-1:0] aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } gpw_state_t;

    gpw_state_t st_q;
    gpw_state_t st_d;

    // ******************************************************
    // helpers
    // ******************************************************
    function automatic gpw_byte_t lane_wr(
        input gpw_byte_t   old,
        input logic [31:0] data,
        input logic [3:0]  strb,
        input int          lane
    );
        gpw_byte_t res;
        res = old;
        if (strb[lane]) begin
            res = data[lane*8 +: 8];
        end
        return res;
    endfunction

    function automatic gpw_byte_t port_view(
        input gpw_byte_t dir,
        input gpw_byte_t pin,
        input gpw_byte_t latch
    );
        return (dir & pin) | (~dir & latch);
    endfunction

    // ******************************************************
    // pin side
    // ******************************************************
    gpw_byte_t fall_a;
    gpw_bank_t pin_rd;
    logic      adc_off;

    assign fall_a = st_q.prev_a & ~st_q.sync2[PORT_A]
                    & st_q.wake_en;

    always_comb begin
        pin_o      = '0;
        pin_oe     = '0;
        pin_pullup = '0;
        pin_rd     = '0;
        adc_off    = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            pin_rd[p] = port_view(st_q.dir[p], st_q.sync2[p],
                                  st_q.data[p]) & IMPL_MASK[p];
            for (int b = 0; b < PW; b++) begin
                adc_off = (p == ADC_PORT) && st_q.adc_sel[b];
                pin_o[p][b]  = st_q.data[p][b];
                pin_oe[p][b] = ~st_q.dir[p][b]
                               & IMPL_MASK[p][b];
                pin_pullup[p][b] = st_q.pu[p][b] & st_q.dir[p][b]
                                   & PU_MASK[p][b]
                                   & ~adc_off;
            end
        end
        if (st_q.fn[FN_PFD]) begin
            pin_o[PORT_A][PFD_BIT] = freq_divider_in;
        end
        for (int n = 0; n < NPWM; n++) begin
            if (st_q.fn[FN_PWM+n]) begin
                pin_o[PORT_D][n] = pwm_in[n];
            end
        end
        for (int c = 0; c < NCOM; c++) begin
            if (st_q.lcd[c]) begin
                pin_oe[PORT_B][c]     = 1'b0;
                pin_pullup[PORT_B][c] = 1'b0;
            end
        end
    end

    // commons idle low unless enable bit c is set and bit c+NCOM is clear
    always_comb begin
        for (int c = 0; c < NCOM; c++) begin
            lcd_common_pins[c] = st_q.lcd[c] & ~st_q.lcd[c+NCOM];
        end
    end

    assign ext_irq_pins[0] = st_q.fn[FN_IRQ]
                           & st_q.dir[PORT_A][IRQ0_BIT]
                           & st_q.sync2[PORT_A][IRQ0_BIT];
    assign ext_irq_pins[1] = st_q.fn[FN_IRQ+1]
                           & st_q.dir[PORT_A][IRQ1_BIT]
                           & st_q.sync2[PORT_A][IRQ1_BIT];
    assign timer_input_pin[0] = st_q.fn[FN_TMR]
                              & st_q.dir[PORT_A][TMR0_BIT]
                              & st_q.sync2[PORT_A][TMR0_BIT];
    assign timer_input_pin[1] = st_q.fn[FN_TMR+1]
                              & st_q.dir[PORT_A][TMR1_BIT]
                              & st_q.sync2[PORT_A][TMR1_BIT];

    assign wake_o = st_q.wake;
    assign irq_o  = |(st_q.istat & st_q.imask);

    // ******************************************************
    // bus handshake outputs
    // ******************************************************
    assign awready = ~st_q.aw_got & ~st_q.bvalid;
    assign wready  = ~st_q.w_got & ~st_q.bvalid;
    assign bvalid  = st_q.bvalid;
    assign bresp   = st_q.bresp;
    assign arready = ~st_q.rvalid;
    assign rvalid  = st_q.rvalid;
    assign rresp   = st_q.rresp;
    assign rdata   = st_q.rdata;

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        logic [AW-1:0] wa;
        logic [AW-1:0] ra;
        logic [2:0]    wp;
        logic [2:0]    rp;
        logic          hit;
        gpw_byte_t     clr;
        wa  = st_q.aw_addr;
        ra  = araddr;
        wp  = wa[4:2];
        rp  = ra[4:2];
        hit = 1'b0;
        clr = BYTE_ZERO;
        st_d = st_q;

        st_d.sync1  = pin_i;
        st_d.sync2  = st_q.sync1;
        st_d.prev_a = st_q.sync2[PORT_A];
        st_d.wake   = sleep_i & (|fall_a);

        if (awvalid && awready) begin
            st_d.aw_got  = 1'b1;
            st_d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            st_d.w_got  = 1'b1;
            st_d.w_data = wdata;
            st_d.w_strb = wstrb;
        end
        if (st_q.bvalid && bready) begin
            st_d.bvalid = 1'b0;
        end

        // register write once address and data are both held
        if (st_q.aw_got && st_q.w_got) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            if (wp < 3'(NPORT) && wa[7:5] == GRP_DATA
                && wa[1:0] == 2'h0) begin
                hit = 1'b1;
                st_d.data[wp] = lane_wr(st_q.data[wp], st_q.w_data,
                                        st_q.w_strb, 0)
                                & IMPL_MASK[wp];
            end else if (wp < 3'(NPORT) && wa[7:5] == GRP_DIR
                         && wa[1:0] == 2'h0) begin
                hit = 1'b1;
                st_d.dir[wp] = lane_wr(st_q.dir[wp], st_q.w_data,
                                       st_q.w_strb, 0)
                               & IMPL_MASK[wp];
            end else if (wp < 3'(NPORT) && wa[7:5] == GRP_PU
                         && wa[1:0] == 2'h0) begin
                hit = 1'b1;
                st_d.pu[wp] = lane_wr(st_q.pu[wp], st_q.w_data,
                                      st_q.w_strb, 0)
                              & PU_MASK[wp];
            end else begin
                unique case (wa)
                    OFS_WAKE: begin
                        hit = 1'b1;
                        st_d.wake_en = lane_wr(st_q.wake_en, st_q.w_data,
                                               st_q.w_strb, 0);
                    end
                    OFS_FN: begin
                        hit = 1'b1;
                        st_d.fn[7:0]  = lane_wr(st_q.fn[7:0], st_q.w_data,
                                                st_q.w_strb, 0);
                        st_d.fn[15:8] = lane_wr(st_q.fn[15:8],
                                                st_q.w_data,
                                                st_q.w_strb, 1);
                    end
                    OFS_ADC: begin
                        hit = 1'b1;
                        st_d.adc_sel = lane_wr(st_q.adc_sel, st_q.w_data,
                                               st_q.w_strb, 0);
                    end
                    OFS_LCD: begin
                        hit = 1'b1;
                        st_d.lcd = lane_wr(st_q.lcd, st_q.w_data,
                                           st_q.w_strb, 0);
                    end
                    OFS_ISTAT: begin
                        hit = 1'b1;
                        clr = lane_wr(BYTE_ZERO, st_q.w_data,
                                      st_q.w_strb, 0);
                    end
                    OFS_IMASK: begin
                        hit = 1'b1;
                        st_d.imask = lane_wr(st_q.imask, st_q.w_data,
                                             st_q.w_strb, 0);
                    end
                    default: hit = 1'b0;
                endcase
            end
            st_d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // sticky wake events, a new edge beats the clear
        st_d.istat = (st_q.istat & ~clr) | fall_a;

        if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = RESP_OKAY;
            st_d.rdata  = WORD_ZERO;
            if (rp < 3'(NPORT) && ra[7:5] == GRP_DATA
                && ra[1:0] == 2'h0) begin
                st_d.rdata[7:0] = pin_rd[rp];
            end else if (rp < 3'(NPORT) && ra[7:5] == GRP_DIR
                         && ra[1:0] == 2'h0) begin
                st_d.rdata[7:0] = st_q.dir[rp];
            end else if (rp < 3'(NPORT) && ra[7:5] == GRP_PU
                         && ra[1:0] == 2'h0) begin
                st_d.rdata[7:0] = st_q.pu[rp];
            end else begin
                unique case (ra)
                    OFS_WAKE:  st_d.rdata[7:0]  = st_q.wake_en;
                    OFS_FN:    st_d.rdata[15:0] = st_q.fn;
                    OFS_ADC:   st_d.rdata[7:0]  = st_q.adc_sel;
                    OFS_LCD:   st_d.rdata[7:0]  = st_q.lcd;
                    OFS_ISTAT: st_d.rdata[7:0]  = st_q.istat;
                    OFS_IMASK: st_d.rdata[7:0]  = st_q.imask;
                    default:   st_d.rresp       = RESP_SLVERR;
                endcase
            end
        end
    end

    // ******************************************************
    // state register
    // ******************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q         <= '0;
            st_q.data    <= DATA_RST;
            st_q.dir     <= DIR_RST;
            st_q.pu      <= PU_RST;
            st_q.wake_en <= WAKE_RST;
            st_q.fn      <= FN_RST;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

// [tb/gpw_chk_sva.sv]
module gpw_chk (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic [1:0]         bresp,
    input wire logic               bvalid,
    input wire logic [31:0]        rdata,
    input wire logic               rvalid,
    input wire gpw_pkg::gpw_bank_t pin_i,
    input wire gpw_pkg::gpw_bank_t pin_oe,
    input wire gpw_pkg::gpw_bank_t pin_pullup,
    input wire logic [1:0]         ext_irq_pins,
    input wire logic [1:0]         timer_input_pin,
    input wire logic [3:0]         lcd_common_pins,
    input wire logic               sleep_i,
    input wire logic               wake_o,
    input wire logic               irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpw_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****
    // pin and bus checks
    // ****
    AST_OE_PU: assert property ((pin_oe & pin_pullup) == '0)
        else $error("pull-high on driven pin");
    AST_OE_IMPL: assert property ((pin_oe & ~IMPL_MASK) == '0)
        else $error("absent pin driven");
    AST_PU_IMPL: assert property ((pin_pullup & ~PU_MASK) == '0)
        else $error("pull-high on pin without one");
    AST_RST_IN: assert property (disable iff (1'b0)
        !aresetn |=> pin_oe == '0 && pin_pullup == '0 && !irq_o)
        else $error("pins not inputs after reset");
    AST_RD_HI: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("read upper half not zero");
    AST_WK_SLP: assert property (wake_o |-> $past(sleep_i))
        else $error("wake while awake");
    AST_WK_EDGE: assert property (wake_o |->
        |($past(pin_i[PORT_A], 4) & ~$past(pin_i[PORT_A], 3)))
        else $error("wake without synced fall");
    AST_IRQ_GATE: assert property ((ext_irq_pins &
        {pin_oe[PORT_A][IRQ1_BIT], pin_oe[PORT_A][IRQ0_BIT]}) == 2'h0)
        else $error("irq pin fed while output");
    AST_TMR_GATE: assert property (|timer_input_pin |->
        !(timer_input_pin[0] && pin_oe[PORT_A][TMR0_BIT]) &&
        !(timer_input_pin[1] && pin_oe[PORT_A][TMR1_BIT]))
        else $error("timer pin fed while output");
    AST_LCD_FREE: assert property (lcd_common_pins != 4'h0 |->
        (lcd_common_pins & pin_oe[PORT_B][3:0]) == 4'h0)
        else $error("common pin driven as port");
    AST_IRQ_HOLD: assert property ($fell(irq_o) && $past(aresetn)
        |-> bvalid)
        else $error("irq dropped without write");
    COV_WAKE: cover property (wake_o);
    COV_IRQ: cover property ($fell(irq_o));
    COV_ERR: cover property (bvalid && bresp == RESP_SLVERR);
endmodule

bind gpw_top gpw_chk u_chk (
    .aclk, .aresetn, .bresp, .bvalid, .rdata, .rvalid, .pin_i, .pin_oe,
    .pin_pullup, .ext_irq_pins, .timer_input_pin, .lcd_common_pins,
    .sleep_i, .wake_o, .irq_o
);

// [tb/gpw_pin_model.sv]
module gpw_pin_model (
    input  wire logic               aclk,
    input  wire gpw_pkg::gpw_bank_t pin_o,
    input  wire gpw_pkg::gpw_bank_t pin_oe,
    input  wire gpw_pkg::gpw_bank_t pin_pullup,
    input  wire gpw_pkg::gpw_bank_t ext_en,
    input  wire gpw_pkg::gpw_bank_t ext_val,
    output gpw_pkg::gpw_bank_t      pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpw_pkg::*;
    gpw_bank_t float_q = '0;
    // ****
    // wire level
    // ****
    // floating pins wander every cycle
    always @(posedge aclk) begin
        float_q <= ~float_q;
    end
    // strong outside driver beats the port
    assign pin_i = (ext_en & ext_val)
        | (~ext_en & pin_oe & pin_o)
        | (~ext_en & ~pin_oe & (pin_pullup | float_q));
endmodule

// [tb/test_gpio_port_dir_pullup_wake.sv]
module test_gpio_port_dir_pullup_wake;
    timeunit 1ns;
    timeprecision 1ps;
    import gpw_pkg::*;
    logic          aclk = 1'b0;
    logic          aresetn, freq_divider_in, sleep_i, wake_o, irq_o;
    logic          awvalid, wvalid, bready, arvalid, rready;
    logic          awready, wready, bvalid, arready, rvalid;
    logic [AW-1:0] awaddr, araddr;
    logic [31:0]   wdata, rdata;
    logic [3:0]    wstrb, pwm_in, lcd_common_pins;
    logic [1:0]    bresp, rresp, ext_irq_pins, timer_input_pin;
    gpw_bank_t     pin_i, pin_o, pin_oe, pin_pullup, ext_en, ext_val;
    int            fails = 0, comparisons = 0, wk = 0;

    always #5 aclk = ~aclk;
    always @(posedge aclk) if (wake_o === 1'b1) wk++;

    gpw_top dut_u (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .pin_i, .pin_o,
        .pin_oe, .pin_pullup, .freq_divider_in, .pwm_in, .ext_irq_pins,
        .timer_input_pin, .lcd_common_pins, .sleep_i, .wake_o, .irq_o
    );
    gpw_pin_model far_u (
        .aclk, .pin_o, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_i
    );
    // ****
    // bus tasks
    // ****
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    function automatic logic [AW-1:0] ra(input logic [2:0] g, input int p);
        return {g, p[2:0], 2'b00};
    endfunction
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (awready && !ad) awvalid <= 1'b0;
            if (wready && !dd) wvalid <= 1'b0;
            ad = ad | awready;
            dd = dd | wready;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk(bresp, er);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [31:0] e,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(rdata, e);
        chk(rresp, er);
        rready <= 1'b0;
    endtask
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        final_report();
    end
    // ****
    // tests
    // ****
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, sleep_i} = '0;
        {awaddr, araddr, wdata, pwm_in, freq_divider_in} = '0;
        wstrb = 4'hf;
        aresetn = 1'b0;
        ext_en = '1;
        ext_val = '1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(pin_oe, '0);
        rd(OFS_WAKE, WORD_ZERO);
        for (int p = 0; p < NPORT; p++) begin
            rd(ra(GRP_DIR, p), 32'(IMPL_MASK[p]));
            rd(ra(GRP_PU, p), WORD_ZERO);
            wr(ra(GRP_DIR, p), 32'hffff_ff00);
            wr(ra(GRP_PU, p), 32'hffff_ffff);
            rd(ra(GRP_DIR, p), WORD_ZERO);
            rd(ra(GRP_PU, p), 32'(PU_MASK[p]));
            chk(pin_oe[p], IMPL_MASK[p]);
            chk(pin_pullup[p], 8'h00);
            wr(ra(GRP_DIR, p), 32'h0000_00ff);
            chk(pin_pullup[p], PU_MASK[p]);
            wr(ra(GRP_PU, p), WORD_ZERO);
        end
        wr(8'h78, 32'h0000_00ff, RESP_SLVERR);
        rd(8'h78, WORD_ZERO, RESP_SLVERR);
        ext_en[4] <= 8'h00;
        ext_val[PORT_D] <= 8'h5a;
        wr(ra(GRP_PU, 4), 32'h0000_00ff);
        repeat (2) @(posedge aclk);
        rd(ra(GRP_DATA, 4), 32'h0000_00ff);
        rd(ra(GRP_DATA, PORT_D), 32'h0000_005a);
        wr(ra(GRP_DIR, PORT_D), 32'h0000_00f0);
        wr(ra(GRP_DATA, PORT_D), 32'h0000_0033);
        rd(ra(GRP_DATA, PORT_D), 32'h0000_0053);
        chk(pin_o[PORT_D][3:0], 4'h3);
        pwm_in <= 4'h6;
        wr(OFS_FN, 32'h0000_0f00);
        chk(pin_o[PORT_D][3:0], 4'h6);
        wr(ra(GRP_DIR, PORT_D), 32'h0000_00f5);
        chk(pin_oe[PORT_D], 8'h0a);
        freq_divider_in <= 1'b1;
        wr(ra(GRP_DATA, PORT_A), WORD_ZERO);
        wr(OFS_FN, 32'h0000_0001);
        chk(pin_oe[PORT_A][PFD_BIT], 1'b0);
        wr(ra(GRP_DIR, PORT_A), 32'h0000_00f7);
        chk(pin_o[PORT_A][PFD_BIT], 1'b1);
        wr(OFS_FN, 32'h0000_001e);
        chk(pin_o[PORT_A][PFD_BIT], 1'b0);
        rd(OFS_FN, 32'h0000_001e);
        wr(ra(GRP_DIR, PORT_A), 32'h0000_00ff);
        chk(ext_irq_pins, 2'h3);
        chk(timer_input_pin, 2'h3);
        rd(ra(GRP_DATA, PORT_A), 32'h0000_00ff);
        wr(ra(GRP_DIR, PORT_A), 32'h0000_002f);
        chk(ext_irq_pins, 2'h0);
        chk(timer_input_pin, 2'h1);
        wr(ra(GRP_DIR, PORT_A), 32'h0000_00ff);
        wr(OFS_FN, WORD_ZERO);
        chk({ext_irq_pins, timer_input_pin}, 4'h0);
        wr(ra(GRP_PU, PORT_B), 32'h0000_00ff);
        wr(OFS_ADC, 32'h0000_0081);
        chk(pin_pullup[PORT_B], 8'h7e);
        rd(OFS_ADC, 32'h0000_0081);
        wr(ra(GRP_DIR, PORT_B), WORD_ZERO);
        wr(OFS_LCD, 32'h0000_000f);
        chk(lcd_common_pins, 4'hf);
        chk(pin_oe[PORT_B], 8'hf0);
        wr(OFS_LCD, 32'h0000_002f);
        chk(lcd_common_pins, 4'hd);
        rd(OFS_LCD, 32'h0000_002f);
        wr(OFS_WAKE, 32'h0000_0001);
        rd(OFS_WAKE, 32'h0000_0001);
        wr(OFS_IMASK, 32'h0000_0001);
        sleep_i <= 1'b1;
        ext_val[PORT_A] <= 8'hfc;
        repeat (8) @(posedge aclk);
        chk(wk, 1);
        chk(irq_o, 1'b1);
        rd(OFS_ISTAT, 32'h0000_0001);
        wr(OFS_ISTAT, 32'h0000_0001);
        chk(irq_o, 1'b0);
        sleep_i <= 1'b0;
        ext_val[PORT_A] <= 8'hff;
        repeat (4) @(posedge aclk);
        ext_val[PORT_A] <= 8'hfe;
        repeat (8) @(posedge aclk);
        chk(wk, 1);
        wr(OFS_IMASK, WORD_ZERO);
        chk(irq_o, 1'b0);
        rd(OFS_ISTAT, 32'h0000_0001);
        rd(OFS_IMASK, WORD_ZERO);
        // reset again in mid-run, all pins back to inputs
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(pin_oe, '0);
        chk(pin_pullup, '0);
        rd(OFS_WAKE, WORD_ZERO);
        rd(ra(GRP_DIR, PORT_B), 32'(IMPL_MASK[PORT_B]));
        rd(ra(GRP_PU, PORT_B), WORD_ZERO);
        rd(ra(GRP_DATA, PORT_D), 32'h0000_005a);
        final_report();
    end
endmodule
